// ### hw/fmio_config.sv
//////////////////////////////////////////////////////////////////////////////
//
// The Avalon-MM slave port is this design's own decision.
module fmio_config (
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst,
   // avalon-mm slave
   input wire logic [7:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [3:0] i_avs_byteenable,
   input wire logic [31:0] i_avs_writedata,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   // framer side, same clock
   input wire logic i_es_enable,
   input wire logic i_rx_sig_reinsert_en,
   input wire logic i_rx_frame_pulse,
   input wire logic i_rx_mf_pulse,
   input wire logic i_rx_crc4_mf_pulse,
   input wire logic i_rx_sig_frame,
   input wire logic i_tx_frame_pulse,
   input wire logic i_tx_mf_pulse,
   input wire logic i_tx_sig_frame,
   input wire logic i_tx_bipolar_pos,
   input wire logic i_tx_bipolar_neg,
   input wire logic i_tx_nrz,
   output logic o_line_e1,
   output logic o_soft_reset_busy,
   output logic o_pport_tristate,
   output logic o_receive_sync_pin_in_pulse,
   output logic o_receive_sync_pin_in_mf,
   output logic o_transmit_sync_pin_in_pulse,
   output logic o_transmit_sync_pin_in_mf,
   // pins
   input wire logic i_rclk_pin,
   input wire logic i_receive_sync_pin_pin,
   input wire logic i_transmit_sync_pin_pin,
   output fmio_pkg::fmio_pins_t o_pin_out,
   output fmio_pkg::fmio_pins_t o_pin_oe_n
);

   //////////////////////////////////////////////////////////////////////////
   logic wait_reg, wait_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [7:0] mm_reg, mm_next, io1_reg, io1_next, io2_reg, io2_next;
   fmio_pkg::fmio_rst_state_t state_reg, state_next;
   logic [2:0] cnt_reg, cnt_next;
   logic [5:0] idx;
   logic wr_hit;

   function automatic logic [7:0] read_mux(input logic [5:0] i, input logic [7:0] a,
                                           input logic [7:0] b, input logic [7:0] c);
      logic [7:0] r;
      r = 8'h00;
      if (i == fmio_pkg::IDX_MASTER_MODE) r = a;
      else if (i == fmio_pkg::IDX_IO_CONFIG_ONE) r = b;
      else if (i == fmio_pkg::IDX_IO_CONFIG_TWO) r = c;
      return r;
   endfunction : read_mux

   assign idx = i_avs_address[7:2];
   // a write lands only on the edge where waitrequest is seen low
   assign wr_hit = i_avs_write && !wait_reg && i_avs_byteenable[0];

   // waitrequest defaults high, so every request costs exactly one wait state
   always_comb begin
      wait_next = 1'b1;
      rdata_next = rdata_reg;
      if ((i_avs_read || i_avs_write) && wait_reg) begin
         wait_next = 1'b0;
         rdata_next = {24'h000000, read_mux(idx, mm_reg, io1_reg, io2_reg)};
      end
   end

   always_comb begin
      mm_next = mm_reg;
      io1_next = io1_reg;
      io2_next = io2_reg;
      state_next = state_reg;
      cnt_next = cnt_reg;
      unique case (state_reg)
         fmio_pkg::FMIO_IDLE: begin
            if (wr_hit && idx == fmio_pkg::IDX_MASTER_MODE) begin
               if (i_avs_writedata[fmio_pkg::SOFTWARE_RESET_BIT]) begin
                  // bit reads 0 here, so any written 1 is a rising edge
                  state_next = fmio_pkg::FMIO_CLEARING;
                  cnt_next = fmio_pkg::SOFT_RESET_CYCLES - 3'h1;
                  mm_next = fmio_pkg::RESET_VALUE | 8'h01;
                  io1_next = fmio_pkg::RESET_VALUE;
                  io2_next = fmio_pkg::RESET_VALUE;
               end else begin
                  mm_next = {4'h0, i_avs_writedata[3:1] & fmio_pkg::MASTER_MODE_MASK[3:1],
                             1'b0};
               end
            end else if (wr_hit && idx == fmio_pkg::IDX_IO_CONFIG_ONE) begin
               io1_next = i_avs_writedata[7:0];
            end else if (wr_hit && idx == fmio_pkg::IDX_IO_CONFIG_TWO) begin
               io2_next = i_avs_writedata[7:0];
            end
         end
         fmio_pkg::FMIO_CLEARING: begin
            // writes are dropped while the register space is being cleared
            mm_next = fmio_pkg::RESET_VALUE | 8'h01;
            io1_next = fmio_pkg::RESET_VALUE;
            io2_next = fmio_pkg::RESET_VALUE;
            cnt_next = cnt_reg - 3'h1;
            if (cnt_reg == 3'h0) begin
               state_next = fmio_pkg::FMIO_IDLE;
               mm_next = fmio_pkg::RESET_VALUE;
            end
         end
      endcase
   end

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         wait_reg <= 1'b1;
         rdata_reg <= 32'h00000000;
         mm_reg <= 8'h00;
         io1_reg <= 8'h00;
         io2_reg <= 8'h00;
         state_reg <= fmio_pkg::FMIO_IDLE;
         cnt_reg <= 3'h0;
      end else begin
         wait_reg <= wait_next;
         rdata_reg <= rdata_next;
         mm_reg <= mm_next;
         io1_reg <= io1_next;
         io2_reg <= io2_next;
         state_reg <= state_next;
         cnt_reg <= cnt_next;
      end
   end

   assign o_avs_waitrequest = wait_reg;
   assign o_avs_readdata = rdata_reg;

   //////////////////////////////////////////////////////////////////////////
   logic [1:0] rclk_s_reg, receive_sync_pin_s_reg, transmit_sync_pin_s_reg;
   logic rfp_d_reg, tfp_d_reg, mf_odd_reg, mf_odd_next;
   fmio_pkg::fmio_pins_t out_reg, out_next, oe_reg, oe_next, func, func_oe;
   logic e1, skip_en, receive_sync_pin_input, mf_sel, rx_frame, rx_mf, tx_frame;
   logic e1_reg, busy_reg, ptri_reg, rin_reg, rin_mf_reg, tin_reg, tin_mf_reg;
   logic [1:0] test;

   assign e1 = mm_reg[fmio_pkg::LINE_STANDARD_SELECT];
   assign test = mm_reg[fmio_pkg::TEST_FIELD_LSB +: 2];
   // the field can only say input once the elastic store is running
   assign receive_sync_pin_input = io1_reg[fmio_pkg::RECEIVE_SYNC_DIRECTION] && i_es_enable;
   assign skip_en = io1_reg[fmio_pkg::RECEIVE_SYNC_SKIP] && !i_es_enable;

   always_comb begin
      mf_sel = i_rx_mf_pulse;
      if (e1 && io1_reg[fmio_pkg::RECEIVE_SYNC_MODE_TWO]) begin
         mf_sel = i_rx_crc4_mf_pulse;
      end
      mf_odd_next = skip_en ? (mf_odd_reg ^ mf_sel) : 1'b0;
      rx_mf = mf_sel && !(skip_en && mf_odd_reg);
      rx_frame = i_rx_frame_pulse || (!e1 && io1_reg[fmio_pkg::RECEIVE_SYNC_MODE_TWO]
                 && i_rx_sig_frame && rfp_d_reg);
      tx_frame = i_tx_frame_pulse || (io1_reg[fmio_pkg::TRANSMIT_SYNC_DOUBLE_WIDE]
                 && i_tx_sig_frame && tfp_d_reg);
      func.receive_sync_pin = io1_reg[fmio_pkg::RECEIVE_SYNC_MODE_ONE] ? rx_mf : rx_frame;
      func.transmit_sync_pin = io1_reg[fmio_pkg::TRANSMIT_SYNC_MODE] ? i_tx_mf_pulse : tx_frame;
      if (io1_reg[fmio_pkg::OUTPUT_FORMAT_SELECT]) begin
         func.tpos = i_tx_nrz;
         func.tneg = 1'b0;
      end else begin
         func.tpos = i_tx_bipolar_pos;
         func.tneg = i_tx_bipolar_neg;
      end
      // a resampled copy of the clock; good for slow line clocks only
      func.rclk = rclk_s_reg[1] ^ io2_reg[fmio_pkg::RECEIVE_CLOCK_INVERT];
      func_oe = '0;
      func_oe.receive_sync_pin = receive_sync_pin_input;
      func_oe.transmit_sync_pin = !io1_reg[fmio_pkg::TRANSMIT_SYNC_DIRECTION];
      out_next = func;
      oe_next = func_oe;
      unique case (test)
         fmio_pkg::TEST_NORMAL: begin
            out_next = func;
         end
         fmio_pkg::TEST_TRISTATE: begin
            oe_next = '1;
         end
         fmio_pkg::TEST_FORCE_LOW: begin
            out_next = '0;
            oe_next = '0;
         end
         fmio_pkg::TEST_FORCE_HIGH: begin
            out_next = '1;
            oe_next = '0;
         end
      endcase
   end

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         rclk_s_reg <= 2'h0;
         receive_sync_pin_s_reg <= 2'h0;
         transmit_sync_pin_s_reg <= 2'h0;
         rfp_d_reg <= 1'b0;
         tfp_d_reg <= 1'b0;
         mf_odd_reg <= 1'b0;
         out_reg <= '0;
         // pins stay undriven until the first clock after reset
         oe_reg <= '1;
         e1_reg <= 1'b0;
         busy_reg <= 1'b0;
         ptri_reg <= 1'b0;
         rin_reg <= 1'b0;
         rin_mf_reg <= 1'b0;
         tin_reg <= 1'b0;
         tin_mf_reg <= 1'b0;
      end else begin
         rclk_s_reg <= {rclk_s_reg[0], i_rclk_pin};
         receive_sync_pin_s_reg <= {receive_sync_pin_s_reg[0], i_receive_sync_pin_pin};
         transmit_sync_pin_s_reg <= {transmit_sync_pin_s_reg[0], i_transmit_sync_pin_pin};
         rfp_d_reg <= i_rx_frame_pulse;
         tfp_d_reg <= i_tx_frame_pulse;
         mf_odd_reg <= mf_odd_next;
         out_reg <= out_next;
         oe_reg <= oe_next;
         e1_reg <= e1;
         busy_reg <= (state_reg == fmio_pkg::FMIO_CLEARING);
         ptri_reg <= (test == fmio_pkg::TEST_TRISTATE);
         rin_reg <= receive_sync_pin_input && receive_sync_pin_s_reg[1];
         rin_mf_reg <= receive_sync_pin_input && io1_reg[fmio_pkg::RECEIVE_SYNC_MODE_ONE]
                       && i_rx_sig_reinsert_en;
         tin_reg <= !io1_reg[fmio_pkg::TRANSMIT_SYNC_DIRECTION] && transmit_sync_pin_s_reg[1];
         tin_mf_reg <= io1_reg[fmio_pkg::TRANSMIT_SYNC_MODE];
      end
   end

   assign o_pin_out = out_reg;
   assign o_pin_oe_n = oe_reg;
   assign o_line_e1 = e1_reg;
   assign o_soft_reset_busy = busy_reg;
   assign o_pport_tristate = ptri_reg;
   assign o_receive_sync_pin_in_pulse = rin_reg;
   assign o_receive_sync_pin_in_mf = rin_mf_reg;
   assign o_transmit_sync_pin_in_pulse = tin_reg;
   assign o_transmit_sync_pin_in_mf = tin_mf_reg;

   //////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_rst);

   srst_width_a: assert property ($rose(mm_reg[0]) |-> mm_reg[0] [*4] ##1 !mm_reg[0])
      else $error("software reset bit did not clear after four cycles");
   srst_clears_a: assert property ($rose(mm_reg[0]) |-> io1_reg == 8'h00 && io2_reg == 8'h00)
      else $error("software reset left configuration set");
   srst_cause_a: assert property ($rose(mm_reg[0]) |-> $past(wr_hit && state_reg ==
      fmio_pkg::FMIO_IDLE && idx == fmio_pkg::IDX_MASTER_MODE && i_avs_writedata[0]))
      else $error("software reset began without a written rising edge");
   test_tristate_a: assert property (test == 2'h1 |=> o_pin_oe_n == 5'h1f)
      else $error("tristate test mode left a pin driven");
   test_low_a: assert property (test == 2'h2 |=> o_pin_out == 5'h00 && o_pin_oe_n == 5'h00)
      else $error("force low test mode not applied");
   nrz_neg_a: assert property (test == 2'h0 && io1_reg[0] |=> !o_pin_out.tneg)
      else $error("negative output not held low in nrz format");
   rclk_inv_a: assert property (test == 2'h0 |=> o_pin_out.rclk ==
      ($past(rclk_s_reg[1]) ^ $past(io2_reg[7])))
      else $error("receive clock output polarity wrong");
   transmit_sync_pin_dir_a: assert property (test == 2'h0 |=> o_pin_oe_n.transmit_sync_pin == !$past(io1_reg[1]))
      else $error("transmit sync direction wrong");
   line_std_a: assert property (##1 o_line_e1 == $past(mm_reg[1]))
      else $error("line standard output does not follow register");
   skip_es_a: assert property (i_es_enable |=> !mf_odd_reg)
      else $error("multiframe skip active with elastic store enabled");
   receive_sync_pin_dir_a: assert property (test == 2'h0 |=> o_pin_oe_n.receive_sync_pin == $past(receive_sync_pin_input))
      else $error("receive sync direction wrong");
   force_high_a: assert property (test == 2'h3 |=> {o_pin_out, o_pin_oe_n} == 10'h3e0)
      else $error("force high test mode not applied");
   srst_drop_a: assert property (busy_reg |-> io1_reg == 8'h00 && io2_reg == 8'h00)
      else $error("write landed while the register space was clearing");
   transmit_sync_pin_mf_a: assert property (test == 2'h0 && io1_reg[2] |=>
      o_pin_out.transmit_sync_pin == $past(i_tx_mf_pulse))
      else $error("transmit sync multiframe pulse not passed");

   srst_seen_c: cover property ($rose(mm_reg[0]) ##4 !mm_reg[0]);
   io_write_c: cover property (wr_hit && idx == fmio_pkg::IDX_IO_CONFIG_ONE);
   force_high_c: cover property (test == 2'h3 ##1 o_pin_out == 5'h1f);
   skip_c: cover property (skip_en && mf_sel && mf_odd_reg);
   receive_sync_pin_in_c: cover property (receive_sync_pin_input && receive_sync_pin_s_reg[1]);
endmodule : fmio_config

// ### hw/fmio_pkg.sv
package fmio_pkg;
   // register indices; byte address is four times the index
   localparam logic [5:0] IDX_MASTER_MODE = 6'h00;
   localparam logic [5:0] IDX_IO_CONFIG_ONE = 6'h01;
   localparam logic [5:0] IDX_IO_CONFIG_TWO = 6'h02;
   localparam logic [7:0] RESET_VALUE = 8'h00;
   // master_mode fields
   localparam int SOFTWARE_RESET_BIT = 0;
   localparam int LINE_STANDARD_SELECT = 1;
   localparam int TEST_FIELD_LSB = 2;
   localparam logic [3:0] MASTER_MODE_MASK = 4'hf;
   localparam logic [1:0] TEST_NORMAL = 2'h0;
   localparam logic [1:0] TEST_TRISTATE = 2'h1;
   localparam logic [1:0] TEST_FORCE_LOW = 2'h2;
   localparam logic [1:0] TEST_FORCE_HIGH = 2'h3;
   // io_config_one fields
   localparam int OUTPUT_FORMAT_SELECT = 0;
   localparam int TRANSMIT_SYNC_DIRECTION = 1;
   localparam int TRANSMIT_SYNC_MODE = 2;
   localparam int TRANSMIT_SYNC_DOUBLE_WIDE = 3;
   localparam int RECEIVE_SYNC_DIRECTION = 4;
   localparam int RECEIVE_SYNC_MODE_ONE = 5;
   localparam int RECEIVE_SYNC_MODE_TWO = 6;
   localparam int RECEIVE_SYNC_SKIP = 7;
   // io_config_two fields
   localparam int RECEIVE_CLOCK_INVERT = 7;
   // clocks spent clearing the register space after a software reset
   localparam logic [2:0] SOFT_RESET_CYCLES = 3'h4;

   typedef struct packed {
      logic tpos;
      logic tneg;
      logic rclk;
      logic receive_sync_pin;
      logic transmit_sync_pin;
   } fmio_pins_t;

   typedef enum logic {FMIO_IDLE, FMIO_CLEARING} fmio_rst_state_t;
endpackage : fmio_pkg

// ### test/tb_top.sv
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   //////////////////////////////////////////////////////////////////////////////
   logic i_core_clk = 1'b0;
   logic i_rst = 1'b1;
   logic [7:0] i_avs_address = 8'h00;
   logic i_avs_read = 1'b0;
   logic i_avs_write = 1'b0;
   logic [3:0] i_avs_byteenable = 4'h1;
   logic [31:0] i_avs_writedata = 32'h0;
   logic [31:0] o_avs_readdata;
   logic o_avs_waitrequest;
   logic es = 1'b0;
   logic rsig = 1'b0;
   logic tsig = 1'b0;
   logic bpos = 1'b1;
   logic bneg = 1'b1;
   logic nrz = 1'b0;
   logic rclk = 1'b1;
   logic [4:0] pl = 5'h00;
   logic reins = 1'b0;
   logic rsp = 1'b0;
   logic tsp = 1'b0;
   logic line_e1, busy, pport, tmf_sel, rin, rinmf, tin;
   fmio_pkg::fmio_pins_t pin_out, pin_oe_n;
   logic [4:0] po, oe;
   logic [1:0] g, h;
   logic [31:0] q;
   int n_errors = 0;
   int compares = 0;
   assign po = pin_out;
   assign oe = pin_oe_n;
   // sync pins and reinsertion are driven so the input-mode outputs are judged too
   fmio_config dut_u (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_avs_address(i_avs_address),
      .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_byteenable(i_avs_byteenable),
      .i_avs_writedata(i_avs_writedata), .o_avs_readdata(o_avs_readdata),
      .o_avs_waitrequest(o_avs_waitrequest), .i_es_enable(es), .i_rx_sig_reinsert_en(reins),
      .i_rx_frame_pulse(pl[0]), .i_rx_mf_pulse(pl[1]), .i_rx_crc4_mf_pulse(pl[2]),
      .i_rx_sig_frame(rsig), .i_tx_frame_pulse(pl[3]), .i_tx_mf_pulse(pl[4]),
      .i_tx_sig_frame(tsig), .i_tx_bipolar_pos(bpos), .i_tx_bipolar_neg(bneg), .i_tx_nrz(nrz),
      .o_line_e1(line_e1), .o_soft_reset_busy(busy), .o_pport_tristate(pport),
      .o_receive_sync_pin_in_pulse(rin), .o_receive_sync_pin_in_mf(rinmf), .o_transmit_sync_pin_in_pulse(tin),
      .o_transmit_sync_pin_in_mf(tmf_sel),
      .i_rclk_pin(rclk), .i_receive_sync_pin_pin(rsp), .i_transmit_sync_pin_pin(tsp), .o_pin_out(pin_out),
      .o_pin_oe_n(pin_oe_n));
   //////////////////////////////////////////////////////////////////////////////
   initial begin
      forever #20 i_core_clk = ~i_core_clk;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic end_sim;
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : end_sim
   // values read at an edge are those of the cycle before it
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
         output logic [31:0] r);
      i_avs_address <= a;
      i_avs_writedata <= {24'h0, d};
      i_avs_write <= w;
      i_avs_read <= ~w;
      @(posedge i_core_clk);
      // only the watchdog limits how long the answer may take
      while (o_avs_waitrequest !== 1'b0) begin
         @(posedge i_core_clk);
      end
      r = o_avs_readdata;
      i_avs_write <= 1'b0;
      i_avs_read <= 1'b0;
      // one idle edge, so a following call never re-drives the strobe in this time step
      @(posedge i_core_clk);
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      logic [31:0] r;
      bus(1'b0, a, 8'h00, r);
      check(r, {24'h0, e});
   endtask : rd
   task automatic settle;
      repeat (4) @(posedge i_core_clk);
   endtask : settle
   task automatic pulse(input int k, input int b, output logic [1:0] r);
      pl[k] <= 1'b1;
      @(posedge i_core_clk);
      pl[k] <= 1'b0;
      @(posedge i_core_clk);
      r[1] = po[b];
      @(posedge i_core_clk);
      r[0] = po[b];
   endtask : pulse
   //////////////////////////////////////////////////////////////////////////////
   initial begin
      #100us;
      n_errors++;
      end_sim;
   end
   initial begin
      repeat (16) @(posedge i_core_clk);
      i_rst <= 1'b0;
      @(posedge i_core_clk);
      rd(8'h00, 8'h00);
      rd(8'h04, 8'h00);
      rd(8'h08, 8'h00);
      check(32'(oe), 32'h01);
      tsp <= 1'b1;
      settle;
      check(32'(tin), 32'h1);
      wr(8'h04, 8'ha5);
      rd(8'h04, 8'ha5);
      wr(8'h0c, 8'h77);
      rd(8'h0c, 8'h00);
      i_avs_byteenable <= 4'h0;
      wr(8'h04, 8'h34);
      i_avs_byteenable <= 4'h1;
      rd(8'h04, 8'ha5);
      wr(8'h00, 8'hf2);
      rd(8'h00, 8'h02);
      settle;
      check(32'(line_e1), 32'h1);
      for (int t = 0; t < 4; t++) begin
         wr(8'h00, 8'(t << 2));
         wr(8'h04, 8'h00);
         settle;
         check(32'(oe), t == 1 ? 32'h1f : (t == 0 ? 32'h01 : 32'h00));
         if (t > 1) check(32'(po), t == 3 ? 32'h1f : 32'h00);
         check(32'(pport), 32'(t == 1));
      end
      wr(8'h00, 8'h00);
      settle;
      check(32'(po[4:3]), 32'h3);
      wr(8'h04, 8'h01);
      settle;
      check(32'(po[4:3]), 32'h0);
      nrz <= 1'b1;
      settle;
      check(32'(po[4:3]), 32'h2);
      check(32'(po[2]), 32'h1);
      wr(8'h08, 8'h80);
      settle;
      check(32'(po[2]), 32'h0);
      check(32'(oe[1]), 32'h0);
      es <= 1'b1;
      wr(8'h04, 8'h10);
      settle;
      check(32'(oe[1]), 32'h1);
      rsp <= 1'b1;
      reins <= 1'b1;
      wr(8'h04, 8'h30);
      settle;
      check(32'(rin), 32'h1);
      check(32'(rinmf), 32'h1);
      reins <= 1'b0;
      rsp <= 1'b0;
      settle;
      check(32'(rinmf), 32'h0);
      check(32'(rin), 32'h0);
      // t1 frame pulses in signaling frames, widened only with receive sync mode two set
      wr(8'h04, 8'h40);
      rsig <= 1'b1;
      settle;
      pulse(0, 1, g);
      check(32'(g), 32'h3);
      wr(8'h04, 8'h00);
      settle;
      pulse(0, 1, g);
      check(32'(g), 32'h2);
      // multiframe pulses, skip has no effect with elastic store on
      wr(8'h04, 8'ha0);
      settle;
      pulse(1, 1, g);
      pulse(1, 1, h);
      check(32'({g, h}), 32'ha);
      es <= 1'b0;
      settle;
      pulse(1, 1, g);
      pulse(1, 1, h);
      check(32'(g[1] ^ h[1]), 32'h1);
      wr(8'h00, 8'h02);
      wr(8'h04, 8'h20);
      settle;
      pulse(2, 1, g);
      pulse(1, 1, h);
      check(32'({g, h}), 32'h2);
      wr(8'h04, 8'h60);
      settle;
      pulse(2, 1, g);
      pulse(1, 1, h);
      check(32'({g, h}), 32'h8);
      wr(8'h04, 8'h0a);
      tsig <= 1'b1;
      settle;
      check(32'(oe[0]), 32'h0);
      check(32'(tin), 32'h0);
      pulse(3, 0, g);
      check(32'(g), 32'h3);
      wr(8'h04, 8'h06);
      settle;
      check(32'(tmf_sel), 32'h1);
      pulse(4, 0, g);
      check(32'(g), 32'h2);
      // software reset: a write landing during clearing must be lost
      wr(8'h08, 8'h5a);
      wr(8'h00, 8'h01);
      wr(8'h08, 8'hff);
      check(32'(busy), 32'h1);
      for (int i = 0; i < 8; i++) begin
         bus(1'b0, 8'h00, 8'h00, q);
         if (q[0] === 1'b0) break;
      end
      check(q, 32'h0);
      rd(8'h04, 8'h00);
      rd(8'h08, 8'h00);
      check(32'(line_e1), 32'h0);
      end_sim;
   end
endmodule : tb_top
